// ===== rtl/eshc_top.sv
// Eye scan hit counter: channel select, shared comparator level, span select, hit accumulator.
// Assumes comparator hit pulses and link clock arrive asynchronous to core_clk,
// and an Avalon-MM master that holds its request until waitrequest is low.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - The selected channel gets the one shared 64-step comparator level and its hits against it are counted.
// - The level steps over all 64 positions spread over the chosen span.
// - Hits at the selected level accumulate in a volatile readable register.
// - The management role comes from a strap caught at reset; writes and counting need a serial level.
// - Four spans are offered and 64 steps are swept in each.
module eshc_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [1:0] mode_strap,
    input wire logic link_clk,
    input wire logic link_l0,
    input wire logic [eshc_pkg::NUM_CH-1:0] cmp_hit,
    input wire logic [eshc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [eshc_pkg::LEVEL_W-1:0] dac_level,
    output logic [eshc_pkg::RANGE_W-1:0] dac_range,
    output logic [eshc_pkg::NUM_CH-1:0] ch_sel
);
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [eshc_pkg::NUM_CH-1:0] hit_s1_reg;
    logic [eshc_pkg::NUM_CH-1:0] hit_s2_reg;
    logic lclk_s1_reg;
    logic lclk_s2_reg;
    logic lclk_s3_reg;
    logic l0_s1_reg;
    logic l0_s2_reg;
    logic [1:0] strap_s1_reg;
    logic [1:0] strap_s2_reg;

    // No reset on the strap pipe, so it is already settled when reset lets go
    always_ff @(posedge core_clk) begin
        strap_s1_reg <= mode_strap;
        strap_s2_reg <= strap_s1_reg;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hit_s1_reg <= '0;
            hit_s2_reg <= '0;
            lclk_s1_reg <= 1'b0;
            lclk_s2_reg <= 1'b0;
            lclk_s3_reg <= 1'b0;
            l0_s1_reg <= 1'b0;
            l0_s2_reg <= 1'b0;
        end else begin
            hit_s1_reg <= cmp_hit;
            hit_s2_reg <= hit_s1_reg;
            lclk_s1_reg <= link_clk;
            lclk_s2_reg <= lclk_s1_reg;
            lclk_s3_reg <= lclk_s2_reg;
            l0_s1_reg <= link_l0;
            l0_s2_reg <= l0_s1_reg;
        end
    end

    // Hits counted only on rising link clock edges, so a held comparator
    // output counts once per link cycle, not once per core cycle
    logic lclk_rise;
    assign lclk_rise = lclk_s2_reg && !lclk_s3_reg;

    // ------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------
    logic strap_done_reg;
    logic [1:0] strap_reg;
    logic mgmt_ok;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done_reg <= 1'b0;
            strap_reg <= eshc_pkg::STRAP_PIN;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_reg <= strap_s2_reg;
        end
    end

    assign mgmt_ok = (strap_reg == eshc_pkg::STRAP_SMB_PRI) ||
                     (strap_reg == eshc_pkg::STRAP_SMB_SEC);

    // ------------------------------------------------------------
    // Avalon-MM slave, one wait cycle per access
    // ------------------------------------------------------------
    eshc_pkg::eshc_bus_t bus_state_reg;
    logic req;
    logic take;
    logic wr_take;

    assign req = avs_read || avs_write;
    assign take = (bus_state_reg == eshc_pkg::ESHC_RESP) && req;
    assign wr_take = take && avs_write && mgmt_ok;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_state_reg <= eshc_pkg::ESHC_IDLE;
        end else begin
            case (bus_state_reg)
                eshc_pkg::ESHC_IDLE: begin
                    if (req) begin
                        bus_state_reg <= eshc_pkg::ESHC_RESP;
                    end
                end
                eshc_pkg::ESHC_RESP: begin
                    bus_state_reg <= eshc_pkg::ESHC_IDLE;
                end
                default: begin
                    bus_state_reg <= eshc_pkg::ESHC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(req && (bus_state_reg == eshc_pkg::ESHC_IDLE));
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [eshc_pkg::CH_W-1:0] ch_reg;
    logic [eshc_pkg::RANGE_W-1:0] range_reg;
    logic en_reg;
    logic [eshc_pkg::LEVEL_W-1:0] level_reg;
    logic level_wr;

    assign level_wr = wr_take && (avs_address == eshc_pkg::OFF_LEVEL) && avs_byteenable[0];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ch_reg <= eshc_pkg::CH_RST;
            range_reg <= eshc_pkg::RANGE_RST;
            en_reg <= 1'b0;
        end else if (wr_take && (avs_address == eshc_pkg::OFF_CTRL)) begin
            if (avs_byteenable[0]) begin
                ch_reg <= avs_writedata[eshc_pkg::CTRL_CH_LSB +: eshc_pkg::CH_W];
                range_reg <= avs_writedata[eshc_pkg::CTRL_RANGE_LSB +: eshc_pkg::RANGE_W];
            end
            if (avs_byteenable[1]) begin
                en_reg <= avs_writedata[eshc_pkg::CTRL_EN_BIT];
            end
        end
    end

    // Six bits cover exactly the 64 steps, no wrap check needed
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_reg <= eshc_pkg::LEVEL_RST;
        end else if (level_wr) begin
            level_reg <= avs_writedata[eshc_pkg::LEVEL_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Hit accumulator
    // ------------------------------------------------------------
    logic [eshc_pkg::HIT_W-1:0] hits_reg;
    logic sat_reg;
    logic hit_now;
    logic running;

    assign running = en_reg && l0_s2_reg && mgmt_ok;
    assign hit_now = running && lclk_rise && hit_s2_reg[ch_reg];

    // A level write clears, and a hit in that same cycle is dropped on
    // purpose: it belongs to the old level
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hits_reg <= eshc_pkg::HITS_RST;
            sat_reg <= 1'b0;
        end else if (level_wr) begin
            hits_reg <= eshc_pkg::HITS_RST;
            sat_reg <= 1'b0;
        end else if (hit_now) begin
            if (hits_reg == eshc_pkg::HITS_MAX) begin
                sat_reg <= 1'b1;
            end else begin
                hits_reg <= hits_reg + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = eshc_pkg::UNMAPPED_DATA;
        case (avs_address)
            eshc_pkg::OFF_CTRL: begin
                rd_mux[eshc_pkg::CTRL_CH_LSB +: eshc_pkg::CH_W] = ch_reg;
                rd_mux[eshc_pkg::CTRL_RANGE_LSB +: eshc_pkg::RANGE_W] = range_reg;
                rd_mux[eshc_pkg::CTRL_EN_BIT] = en_reg;
            end
            eshc_pkg::OFF_LEVEL: begin
                rd_mux[eshc_pkg::LEVEL_W-1:0] = level_reg;
            end
            eshc_pkg::OFF_HITS: begin
                rd_mux = hits_reg;
            end
            eshc_pkg::OFF_STATUS: begin
                rd_mux[eshc_pkg::STAT_MGMT_BIT] = mgmt_ok;
                rd_mux[eshc_pkg::STAT_ROLE_BIT] = (strap_reg == eshc_pkg::STRAP_SMB_SEC);
                rd_mux[eshc_pkg::STAT_RUN_BIT] = running;
                rd_mux[eshc_pkg::STAT_SAT_BIT] = sat_reg;
            end
            default: begin
                rd_mux = eshc_pkg::UNMAPPED_DATA;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= eshc_pkg::UNMAPPED_DATA;
        end else if (req && (bus_state_reg == eshc_pkg::ESHC_IDLE) && avs_read) begin
            avs_readdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Analog-side outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dac_level <= eshc_pkg::LEVEL_RST;
            dac_range <= eshc_pkg::RANGE_RST;
            ch_sel <= '0;
        end else begin
            dac_level <= level_reg;
            dac_range <= range_reg;
            ch_sel <= running ? (eshc_pkg::NUM_CH'(1) << ch_reg) : '0;
        end
    end
endmodule : eshc_top

// ===== rtl/eshc_pkg.sv
// Package for the eye scan hit counter: register map, field layout, reset values.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package eshc_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int LEVEL_W = 6;
    localparam int NUM_LEVELS = 64;
    localparam int RANGE_W = 2;
    localparam int HIT_W = 32;
    localparam int ADDR_W = 4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_LEVEL = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_HITS = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hC;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_CH_LSB = 0;
    localparam int CTRL_RANGE_LSB = 4;
    localparam int CTRL_EN_BIT = 8;
    localparam int STAT_MGMT_BIT = 0;
    localparam int STAT_ROLE_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    localparam int STAT_SAT_BIT = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CH_W-1:0] CH_RST = 2'h0;
    localparam logic [RANGE_W-1:0] RANGE_RST = 2'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 6'h00;
    localparam logic [HIT_W-1:0] HITS_RST = 32'h0000_0000;
    localparam logic [HIT_W-1:0] HITS_MAX = 32'hFFFF_FFFF;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Strap encodings; only the two serial-management levels allow writes
    localparam logic [1:0] STRAP_PIN = 2'h0;
    localparam logic [1:0] STRAP_SMB_PRI = 2'h1;
    localparam logic [1:0] STRAP_SMB_SEC = 2'h2;

    typedef enum logic [1:0] {
        ESHC_IDLE = 2'b00,
        ESHC_RESP = 2'b01
    } eshc_bus_t;
endpackage : eshc_pkg

// ===== sim/eshc_link_model.sv
// Link-side model: free-running link clock, L0 flag, per-channel hits.
// Assumes the bench chooses which channels see hits and when L0 holds.
`timescale 1ns/1ps
module eshc_link_model (
    input wire logic [3:0] hit_mask,
    input wire logic l0_req,
    output logic link_clk,
    output logic link_l0,
    output logic [3:0] cmp_hit
);
    logic pat;
    initial begin
        link_clk = 1'h0;
        pat = 1'h0;
        cmp_hit = 4'h0;
        forever #40 link_clk = ~link_clk;
    end
    // Change on falling edge, clear of the rise the block samples
    always @(negedge link_clk) begin
        pat <= ~pat;
        cmp_hit <= hit_mask & {4{pat}};
    end
    // L0 stands for a link trained with its equalizer already settled
    assign link_l0 = l0_req;
endmodule : eshc_link_model

// ===== sim/eshc_monitor.sv
// Checker on the top-level ports of the hit counter.
// Assumes the strap changes only while sys_rst is held.
`timescale 1ns/1ps
module eshc_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [1:0] mode_strap,
    input wire logic link_l0,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [5:0] dac_level,
    input wire logic [3:0] ch_sel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence lvl_done;
        avs_write && !avs_waitrequest && avs_address == eshc_pkg::OFF_LEVEL
            && avs_byteenable[0] && mode_strap inside {2'h1, 2'h2};
    endsequence
    sequence req_start;
        $rose(avs_read || avs_write);
    endsequence
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    answer_time_a: assert property (req_start |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low with no request");
    level_follow_a: assert property (lvl_done |=> ##1
        dac_level == $past(avs_writedata[5:0], 2))
        else $error("level output does not follow written level");
    sel_onehot_a: assert property ($onehot0(ch_sel))
        else $error("more than one channel selected");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest
        && avs_address[1:0] != 2'h0 |-> avs_readdata == eshc_pkg::UNMAPPED_DATA)
        else $error("unmapped read not zero");
    no_link_idle_a: assert property (!link_l0 [*5] |-> ch_sel == 4'h0)
        else $error("channel selected while link not in L0");
    read_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
endmodule : eshc_monitor

// ===== sim/eshc_top_bench.sv
// Bench for the hit counter: register sweeps, hit counting, L0 gating.
// Assumes the link model in its own file and a steady serial strap outside the strap test.
`timescale 1ns/1ps
module eshc_top_bench;
    logic core_clk = 1'h0, sys_rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
    logic [3:0] avs_address = 4'h0, hit_mask = 4'h0, ch_sel, cmp_hit;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, d, h1;
    logic avs_waitrequest, link_clk, link_l0, l0_req = 1'h1;
    logic [5:0] dac_level;
    logic [1:0] dac_range;
    logic [1:0] mode_strap = 2'h1;
    int fails = 0, checks = 0;
    eshc_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .mode_strap(mode_strap),
        .link_clk(link_clk), .link_l0(link_l0), .cmp_hit(cmp_hit),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dac_level(dac_level), .dac_range(dac_range), .ch_sel(ch_sel));
    eshc_link_model lm (.hit_mask(hit_mask), .l0_req(l0_req), .link_clk(link_clk),
        .link_l0(link_l0), .cmp_hit(cmp_hit));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
        d = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : acc
    task automatic ctrl(input logic [1:0] c, input logic [1:0] r);
        acc(1'h1, eshc_pkg::OFF_CTRL, {23'h0, 1'h1, 2'h0, r, 2'h0, c});
        repeat (4) @(posedge core_clk);
    endtask : ctrl
    task automatic t_span();
        for (int r = 0; r < 4; r++) begin
            ctrl(2'h1, r[1:0]);
            chk({30'h0, dac_range}, r);
            chk({28'h0, ch_sel}, 32'h0000_0002);
        end
    endtask : t_span
    task automatic t_sweep();
        for (int l = 0; l < eshc_pkg::NUM_LEVELS; l++) begin
            acc(1'h1, eshc_pkg::OFF_LEVEL, l);
            repeat (3) @(posedge core_clk);
            chk({26'h0, dac_level}, l);
            acc(1'h0, eshc_pkg::OFF_HITS, 32'h0000_0000);
            chk(d, 32'h0000_0000);
        end
    endtask : t_sweep
    task automatic t_hits();
        ctrl(2'h2, 2'h3);
        hit_mask <= 4'hB;
        acc(1'h1, eshc_pkg::OFF_LEVEL, 32'h0000_0005);
        repeat (400) @(posedge core_clk);
        acc(1'h0, eshc_pkg::OFF_HITS, 32'h0000_0000);
        chk(d, 32'h0000_0000);
        hit_mask <= 4'hF;
        repeat (400) @(posedge core_clk);
        acc(1'h0, eshc_pkg::OFF_HITS, 32'h0000_0000);
        h1 = d;
        // Half-rate hits over about 25 link cycles
        chk({31'h0, h1 >= 32'h0000_000A && h1 <= 32'h0000_000E}, 32'h0000_0001);
        repeat (1200) @(posedge core_clk);
        acc(1'h0, eshc_pkg::OFF_HITS, 32'h0000_0000);
        chk({31'h0, d > h1}, 32'h0000_0001);
        // About 50 hits by now, so one after dividing by 32
        chk(d >> 5, 32'h0000_0001);
        hit_mask <= 4'h0;
        repeat (100) @(posedge core_clk);
        acc(1'h0, eshc_pkg::OFF_HITS, 32'h0000_0000);
        acc(1'h1, eshc_pkg::OFF_LEVEL, 32'h0000_0005);
        acc(1'h0, eshc_pkg::OFF_HITS, 32'h0000_0000);
        chk(d, 32'h0000_0000);
    endtask : t_hits
    task automatic t_link();
        l0_req <= 1'h0;
        hit_mask <= 4'hF;
        repeat (10) @(posedge core_clk);
        chk({28'h0, ch_sel}, 32'h0000_0000);
        acc(1'h1, eshc_pkg::OFF_LEVEL, 32'h0000_0009);
        repeat (400) @(posedge core_clk);
        acc(1'h0, eshc_pkg::OFF_HITS, 32'h0000_0000);
        chk(d, 32'h0000_0000);
        l0_req <= 1'h1;
    endtask : t_link
    // Mid-run resets: a non-serial strap refuses writes, the secondary one allows them
    task automatic t_strap();
        for (int s = 0; s < 2; s++) begin
            sys_rst <= 1'h1;
            mode_strap <= s[0] ? 2'h2 : 2'h0;
            repeat (4) @(posedge core_clk);
            sys_rst <= 1'h0;
            repeat (4) @(posedge core_clk);
            acc(1'h1, eshc_pkg::OFF_LEVEL, 32'h0000_0007);
            acc(1'h0, eshc_pkg::OFF_LEVEL, 32'h0000_0000);
            chk(d, s[0] ? 32'h0000_0007 : 32'h0000_0000);
            acc(1'h0, eshc_pkg::OFF_STATUS, 32'h0000_0000);
            chk(d, s[0] ? 32'h0000_0003 : 32'h0000_0000);
        end
    endtask : t_strap
    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        chk({19'h0, avs_waitrequest, dac_level, dac_range, ch_sel}, 32'h0000_1000);
        sys_rst <= 1'h0;
        repeat (4) @(posedge core_clk);
        acc(1'h0, eshc_pkg::OFF_STATUS, 32'h0000_0000);
        chk(d & 32'h0000_000F, 32'h0000_0001);
        acc(1'h0, 4'h2, 32'h0000_0000);
        chk(d, eshc_pkg::UNMAPPED_DATA);
        t_span();
        t_sweep();
        t_hits();
        t_link();
        t_strap();
        tally_and_finish();
    end
endmodule : eshc_top_bench
bind eshc_top eshc_monitor mon (.core_clk(core_clk), .sys_rst(sys_rst),
    .mode_strap(mode_strap), .link_l0(link_l0), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dac_level(dac_level), .ch_sel(ch_sel));
